/* core/tmc_core.v */
// Functional notes
// - configuration register at 03h and 09h, same behaviour, resets to zero.
// - global mask bit 7 holds alert off; status keeps updating.
// - bit 6 zero runs conversions, one enters standby with none except one-shots.
// - bit 5 selects comparator alert mode and overrides global mask.
// - bit 4 turns off series resistance correction on outer channel.
// - bit 2 selects plain binary or offset binary extended range.
// - bit 1 caps dynamic averaging at 1x.
// - rate register at 04h and 0Ah, 4-bit code, resets to 4 per second.
// - codes 0h-Ah give 1/16 to 64 per second; Bh-Fh give 1 per second.
// - temperature above high limit sets high status and alert.
// - temperature at or below low limit sets low status and alert.
// - limits at both aliases; outer limits have 3 fraction bits; high default 85.
// - limit changes in standby act only from the next conversion.
// - two scratch bytes read back what was written, nothing else.
// - one-shot write in standby while idle starts one conversion; reads zero.
// - one-shot writes in active mode are ignored.
// - temperature above a critical limit asserts critical output; defaults 85.
// - critical output ignores every mask.
// - critical output releases below critical limit minus hysteresis, default 10.
// - busy reads one during conversion and never drives the pins.
// - comparator alert follows only high limit, releases below high minus hysteresis.
`timescale 1ns/1ps
`include "tmc_regs.vh"
module tmc_core #(
    parameter TICK_CYCLES = `TMC_TICK_CYCLES
) (
    // clock and reset
    input wire core_clk_i,
    input wire reset_n_i,
    // register access from the serial bus engine
    input wire reg_wr_i,
    input wire reg_rd_i,
    input wire [7:0] reg_addr_i,
    input wire [7:0] reg_wdata_i,
    output reg [7:0] reg_rdata_o,
    // conversion engine
    output reg conv_start_o,
    input wire conv_done_i,
    input wire [10:0] inner_temp_i,
    input wire [10:0] outer_temp_i,
    input wire diode_fault_i,
    // converter settings
    output wire standby_o,
    output wire extended_range_o,
    output wire series_resistance_comp_off_o,
    output wire dynamic_averaging_off_o,
    output wire [3:0] sample_rate_code_o,
    output reg busy_o,
    // status towards the status register
    input wire status_clear_i,
    output reg [4:0] limit_status_o,
    output reg [1:0] crit_status_o,
    // pins, active low
    output reg alert_n_o,
    output reg crit_n_o
);
    localparam ST_IDLE = 2'b01;
    localparam ST_CONV = 2'b10;
    localparam CH_IN = 0;
    localparam CH_OUT = 1;

    reg [7:0] cfg_ff;
    reg [3:0] rate_ff;
    reg [7:0] in_hi_ff;
    reg [7:0] in_lo_ff;
    reg [7:0] out_hi_ff;
    reg [7:0] out_lo_ff;
    reg [2:0] out_hi_frac_ff;
    reg [2:0] out_lo_frac_ff;
    reg [7:0] spare_a_ff;
    reg [7:0] spare_b_ff;
    reg [7:0] out_crit_ff;
    reg [7:0] in_crit_ff;
    reg [7:0] hyst_ff;
    reg [1:0] state_ff;
    reg [1:0] nxt_state;
    reg nxt_start;
    reg [1:0] cmp_alert_ff;
    reg [1:0] nxt_cmp_alert;
    reg [1:0] nxt_crit;
    reg [4:0] nxt_status;
    reg nxt_alert_n;
    reg [7:0] nxt_rdata;

    wire [7:0] wr_addr;
    wire [7:0] rd_addr;
    wire cfg_wr;
    wire one_shot_wr;
    wire resume;
    wire timer_fire;
    wire start_req;
    wire timer_start;
    wire one_shot_start;
    wire [21:0] temp_bus;
    wire [21:0] high_bus;
    wire [21:0] low_bus;
    wire [15:0] crit_bus;
    wire [1:0] above_high;
    wire [1:0] at_low;
    wire [1:0] high_release;
    wire [1:0] above_crit;
    wire [1:0] crit_release;
    wire judge;
    wire [4:0] status_hits;
    wire [1:0] crit_set;
    wire [1:0] crit_clr;
    wire [1:0] cmp_set;
    wire [1:0] cmp_clr;

    // fold alias addresses onto the primary offset
    function [7:0] tmc_fold_addr;
        input [7:0] addr;
        begin
            if (addr >= `TMC_ADDR_CFG_ALIAS && addr <= `TMC_ADDR_OUT_LO_ALIAS) begin
                tmc_fold_addr = addr - `TMC_ALIAS_OFFSET;
            end else begin
                tmc_fold_addr = addr;
            end
        end
    endfunction

    assign wr_addr = tmc_fold_addr(reg_addr_i);
    assign rd_addr = tmc_fold_addr(reg_addr_i);
    assign cfg_wr = reg_wr_i && (wr_addr == `TMC_ADDR_CFG);
    assign one_shot_wr = reg_wr_i && (reg_addr_i == `TMC_ADDR_ONE_SHOT);
    assign resume = cfg_wr && cfg_ff[`TMC_CFG_STANDBY] && !reg_wdata_i[`TMC_CFG_STANDBY];

    assign standby_o = cfg_ff[`TMC_CFG_STANDBY];
    assign extended_range_o = cfg_ff[`TMC_CFG_RANGE];
    assign series_resistance_comp_off_o = cfg_ff[`TMC_CFG_REC_OFF];
    assign dynamic_averaging_off_o = cfg_ff[`TMC_CFG_DAVG_OFF];
    assign sample_rate_code_o = rate_ff;

    // register writes
    always @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cfg_ff <= `TMC_RST_CFG;
            rate_ff <= `TMC_RST_RATE;
            in_hi_ff <= `TMC_RST_HI;
            in_lo_ff <= `TMC_RST_LO;
            out_hi_ff <= `TMC_RST_HI;
            out_lo_ff <= `TMC_RST_LO;
            out_hi_frac_ff <= `TMC_RST_FRAC;
            out_lo_frac_ff <= `TMC_RST_FRAC;
            spare_a_ff <= `TMC_RST_SPARE;
            spare_b_ff <= `TMC_RST_SPARE;
            out_crit_ff <= `TMC_RST_CRIT;
            in_crit_ff <= `TMC_RST_CRIT;
            hyst_ff <= `TMC_RST_HYST;
        end else if (reg_wr_i) begin
            case (wr_addr)
                `TMC_ADDR_CFG: cfg_ff <= reg_wdata_i & `TMC_CFG_WMASK;
                `TMC_ADDR_RATE: rate_ff <= reg_wdata_i[3:0];
                `TMC_ADDR_IN_HI: in_hi_ff <= reg_wdata_i;
                `TMC_ADDR_IN_LO: in_lo_ff <= reg_wdata_i;
                `TMC_ADDR_OUT_HI_INT: out_hi_ff <= reg_wdata_i;
                `TMC_ADDR_OUT_LO_INT: out_lo_ff <= reg_wdata_i;
                `TMC_ADDR_OUT_HI_FRAC: out_hi_frac_ff <= reg_wdata_i[7:5];
                `TMC_ADDR_OUT_LO_FRAC: out_lo_frac_ff <= reg_wdata_i[7:5];
                `TMC_ADDR_SPARE_A: spare_a_ff <= reg_wdata_i;
                `TMC_ADDR_SPARE_B: spare_b_ff <= reg_wdata_i;
                `TMC_ADDR_OUT_CRIT: out_crit_ff <= reg_wdata_i;
                `TMC_ADDR_IN_CRIT: in_crit_ff <= reg_wdata_i;
                `TMC_ADDR_CRIT_HYST: hyst_ff <= reg_wdata_i;
                default: begin
                end
            endcase
        end
    end

    // read data, registered one cycle after the strobe
    always @* begin
        nxt_rdata = 8'h00;
        case (rd_addr)
            `TMC_ADDR_CFG: nxt_rdata = cfg_ff;
            `TMC_ADDR_RATE: nxt_rdata = {4'h0, rate_ff};
            `TMC_ADDR_IN_HI: nxt_rdata = in_hi_ff;
            `TMC_ADDR_IN_LO: nxt_rdata = in_lo_ff;
            `TMC_ADDR_OUT_HI_INT: nxt_rdata = out_hi_ff;
            `TMC_ADDR_OUT_LO_INT: nxt_rdata = out_lo_ff;
            `TMC_ADDR_OUT_HI_FRAC: nxt_rdata = {out_hi_frac_ff, 5'h00};
            `TMC_ADDR_OUT_LO_FRAC: nxt_rdata = {out_lo_frac_ff, 5'h00};
            `TMC_ADDR_ONE_SHOT: nxt_rdata = 8'h00;
            `TMC_ADDR_SPARE_A: nxt_rdata = spare_a_ff;
            `TMC_ADDR_SPARE_B: nxt_rdata = spare_b_ff;
            `TMC_ADDR_OUT_CRIT: nxt_rdata = out_crit_ff;
            `TMC_ADDR_IN_CRIT: nxt_rdata = in_crit_ff;
            `TMC_ADDR_CRIT_HYST: nxt_rdata = hyst_ff;
            default: nxt_rdata = 8'h00;
        endcase
    end

    always @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            reg_rdata_o <= nxt_rdata;
        end
    end

    tmc_rate_timer #(
        .TICK_CYCLES(TICK_CYCLES),
        .CNT_W(32)
    ) u_rate_timer (
        .clk_i(core_clk_i),
        .reset_n_i(reset_n_i),
        .run_i(!cfg_ff[`TMC_CFG_STANDBY]),
        .restart_i(resume),
        .code_i(rate_ff),
        .fire_o(timer_fire)
    );

    // conversion sequencing
    assign timer_start = timer_fire && !cfg_ff[`TMC_CFG_STANDBY];
    assign one_shot_start = one_shot_wr && cfg_ff[`TMC_CFG_STANDBY];
    assign start_req = timer_start || one_shot_start || resume;

    always @* begin
        nxt_state = state_ff;
        nxt_start = 1'b0;
        case (state_ff)
            ST_IDLE: begin
                if (start_req) begin
                    nxt_state = ST_CONV;
                    nxt_start = 1'b1;
                end
            end
            ST_CONV: begin
                if (conv_done_i) begin
                    nxt_state = ST_IDLE;
                end
            end
            default: nxt_state = ST_IDLE;
        endcase
    end

    always @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_ff <= ST_IDLE;
            conv_start_o <= 1'b0;
            busy_o <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            conv_start_o <= nxt_start;
            busy_o <= (nxt_state == ST_CONV);
        end
    end

    // per channel compare, index 0 inner, 1 outer
    assign temp_bus = {outer_temp_i, inner_temp_i};
    assign high_bus = {out_hi_ff, out_hi_frac_ff, in_hi_ff, 3'b000};
    assign low_bus = {out_lo_ff, out_lo_frac_ff, in_lo_ff, 3'b000};
    assign crit_bus = {out_crit_ff, in_crit_ff};

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch = ch + 1) begin : g_chan
            tmc_limit_cmp u_cmp (
                .temp_i(temp_bus[ch*11 +: 11]),
                .high_i(high_bus[ch*11 +: 11]),
                .low_i(low_bus[ch*11 +: 11]),
                .crit_i(crit_bus[ch*8 +: 8]),
                .hyst_i(hyst_ff),
                .above_high_o(above_high[ch]),
                .at_low_o(at_low[ch]),
                .high_release_o(high_release[ch]),
                .above_crit_o(above_crit[ch]),
                .crit_release_o(crit_release[ch])
            );
        end
    endgenerate

    // results count only at the end of a conversion of ours
    assign judge = conv_done_i && (state_ff == ST_CONV);
    assign status_hits = {above_high[CH_IN], at_low[CH_IN], above_high[CH_OUT],
        at_low[CH_OUT], diode_fault_i};
    assign crit_set = above_crit & {2{judge}};
    assign crit_clr = crit_release & {2{judge}};
    assign cmp_set = above_high & {2{judge}};
    assign cmp_clr = high_release & {2{judge}};

    // set has priority, release only below the hysteresis band
    function tmc_hyst_flag;
        input cur;
        input set;
        input rel;
        begin
            if (set) begin
                tmc_hyst_flag = 1'b1;
            end else if (rel) begin
                tmc_hyst_flag = 1'b0;
            end else begin
                tmc_hyst_flag = cur;
            end
        end
    endfunction

    // sticky status, set wins over a clear in the same cycle
    always @* begin
        nxt_status = limit_status_o;
        if (status_clear_i) begin
            nxt_status = 5'h00;
        end
        if (judge) begin
            nxt_status = nxt_status | status_hits;
        end
    end

    // per channel flags with hysteresis
    always @* begin
        nxt_crit[0] = tmc_hyst_flag(crit_status_o[0], crit_set[0], crit_clr[0]);
        nxt_crit[1] = tmc_hyst_flag(crit_status_o[1], crit_set[1], crit_clr[1]);
        nxt_cmp_alert[0] = tmc_hyst_flag(cmp_alert_ff[0], cmp_set[0], cmp_clr[0]);
        nxt_cmp_alert[1] = tmc_hyst_flag(cmp_alert_ff[1], cmp_set[1], cmp_clr[1]);
    end

    // comparator mode ignores the global mask
    always @* begin
        if (cfg_ff[`TMC_CFG_COMPARATOR]) begin
            nxt_alert_n = !(|nxt_cmp_alert);
        end else begin
            nxt_alert_n = !((|nxt_status) && !cfg_ff[`TMC_CFG_MASK_ALL]);
        end
    end

    always @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            limit_status_o <= 5'h00;
            cmp_alert_ff <= 2'b00;
            crit_status_o <= 2'b00;
            alert_n_o <= 1'b1;
            crit_n_o <= 1'b1;
        end else begin
            limit_status_o <= nxt_status;
            cmp_alert_ff <= nxt_cmp_alert;
            crit_status_o <= nxt_crit;
            alert_n_o <= nxt_alert_n;
            crit_n_o <= !(|nxt_crit);
        end
    end
endmodule // tmc_core

/* core/tmc_limit_cmp.v */
`timescale 1ns/1ps
module tmc_limit_cmp (
    // measured value and high/low limits 8.3 fixed point, critical limit and hysteresis integer only
    input wire [10:0] temp_i,
    input wire [10:0] high_i,
    input wire [10:0] low_i,
    input wire [7:0] crit_i,
    input wire [7:0] hyst_i,
    // compare results
    output wire above_high_o,
    output wire at_low_o,
    output wire high_release_o,
    output wire above_crit_o,
    output wire crit_release_o
);
    wire [11:0] temp_plus_hyst;

    // add instead of subtract so a small limit cannot wrap
    assign temp_plus_hyst = {1'b0, temp_i} + {1'b0, hyst_i, 3'b000};
    assign above_high_o = (temp_i > high_i);
    assign at_low_o = (temp_i <= low_i);
    assign high_release_o = (temp_plus_hyst < {1'b0, high_i});
    assign above_crit_o = (temp_i > {crit_i, 3'b000});
    assign crit_release_o = (temp_plus_hyst < {1'b0, crit_i, 3'b000});
endmodule // tmc_limit_cmp

/* core/tmc_rate_timer.v */
`timescale 1ns/1ps
`include "tmc_regs.vh"
module tmc_rate_timer #(
    parameter TICK_CYCLES = `TMC_TICK_CYCLES,
    parameter CNT_W = 21
) (
    // clock and reset
    input wire clk_i,
    input wire reset_n_i,
    // control
    input wire run_i,
    input wire restart_i,
    input wire [3:0] code_i,
    // conversion request
    output reg fire_o
);
    reg [CNT_W-1:0] cyc_ff;
    reg [10:0] tick_ff;
    reg [3:0] code_ff;
    wire tick_end;
    wire restart;

    // ticks of 1/64 s per conversion interval
    function [10:0] tmc_interval;
        input [3:0] code;
        begin
            if (code <= `TMC_RATE_MAX_CODE) begin
                tmc_interval = `TMC_RATE_SLOW_TICKS >> code;
            end else begin
                tmc_interval = `TMC_RATE_DFLT_TICKS;
            end
        end
    endfunction

    assign tick_end = (cyc_ff == TICK_CYCLES[CNT_W-1:0] - 1'b1);
    assign restart = restart_i || !run_i || (code_i != code_ff);

    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cyc_ff <= {CNT_W{1'b0}};
            tick_ff <= 11'h000;
            code_ff <= `TMC_RST_RATE;
            fire_o <= 1'b0;
        end else begin
            code_ff <= code_i;
            fire_o <= 1'b0;
            if (restart) begin
                cyc_ff <= {CNT_W{1'b0}};
                tick_ff <= 11'h000;
            end else if (tick_end) begin
                cyc_ff <= {CNT_W{1'b0}};
                if (tick_ff == tmc_interval(code_i) - 1'b1) begin
                    tick_ff <= 11'h000;
                    fire_o <= 1'b1;
                end else begin
                    tick_ff <= tick_ff + 1'b1;
                end
            end else begin
                cyc_ff <= cyc_ff + 1'b1;
            end
        end
    end
endmodule // tmc_rate_timer

/* core/tmc_regs.vh */
`ifndef TMC_REGS_VH
`define TMC_REGS_VH

// register offsets
`define TMC_ADDR_CFG         8'h03
`define TMC_ADDR_RATE        8'h04
`define TMC_ADDR_IN_HI       8'h05
`define TMC_ADDR_IN_LO       8'h06
`define TMC_ADDR_OUT_HI_INT  8'h07
`define TMC_ADDR_OUT_LO_INT  8'h08
`define TMC_ADDR_CFG_ALIAS   8'h09
`define TMC_ADDR_RATE_ALIAS  8'h0A
`define TMC_ADDR_IN_HI_ALIAS 8'h0B
`define TMC_ADDR_IN_LO_ALIAS 8'h0C
`define TMC_ADDR_OUT_HI_ALIAS 8'h0D
`define TMC_ADDR_OUT_LO_ALIAS 8'h0E
`define TMC_ADDR_ONE_SHOT    8'h0F
`define TMC_ADDR_SPARE_A     8'h11
`define TMC_ADDR_SPARE_B     8'h12
`define TMC_ADDR_OUT_HI_FRAC 8'h13
`define TMC_ADDR_OUT_LO_FRAC 8'h14
`define TMC_ADDR_OUT_CRIT    8'h19
`define TMC_ADDR_IN_CRIT     8'h20
`define TMC_ADDR_CRIT_HYST   8'h21
// distance from an alias to its primary offset
`define TMC_ALIAS_OFFSET     8'h06

// reset values
`define TMC_RST_CFG          8'h00
`define TMC_RST_RATE         4'h6
`define TMC_RST_HI           8'h55
`define TMC_RST_LO           8'h00
`define TMC_RST_FRAC         3'h0
`define TMC_RST_SPARE        8'h00
`define TMC_RST_CRIT         8'h55
`define TMC_RST_HYST         8'h0A

// configuration bit positions
`define TMC_CFG_MASK_ALL     7
`define TMC_CFG_STANDBY      6
`define TMC_CFG_COMPARATOR   5
`define TMC_CFG_REC_OFF      4
`define TMC_CFG_RANGE        2
`define TMC_CFG_DAVG_OFF     1
// writable configuration bits (3 and 0 stay zero)
`define TMC_CFG_WMASK        8'hF6

// rate codes
`define TMC_RATE_MAX_CODE    4'hA
`define TMC_RATE_DFLT_TICKS  11'h040
`define TMC_RATE_SLOW_TICKS  11'h400

// timing: base tick is the 64 per second period
`define TMC_CLK_PERIOD_NS    8
`define TMC_TICK_PERIOD_NS   15625000
`define TMC_TICK_CYCLES      (`TMC_TICK_PERIOD_NS / `TMC_CLK_PERIOD_NS)

`endif

/* verif/tb_temp_monitor_control_limits.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fail_count++; \
    $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module tb_temp_monitor_control_limits;
    reg core_clk_i = 1'b0;
    reg reset_n_i = 1'b0;
    reg reg_wr_i = 1'b0;
    reg reg_rd_i = 1'b0;
    reg [7:0] reg_addr_i = 8'h00;
    reg [7:0] reg_wdata_i = 8'h00;
    reg status_clear_i = 1'b0;
    reg [10:0] t_in = 11'h100;
    reg [10:0] t_out = 11'h100;
    reg t_flt = 1'b0;
    wire [7:0] reg_rdata_o;
    wire conv_start_o, conv_done_i, diode_fault_i, busy_o, alert_n_o, crit_n_o;
    wire standby_o, extended_range_o, series_resistance_comp_off_o, dynamic_averaging_off_o;
    wire [10:0] inner_temp_i, outer_temp_i;
    wire [3:0] sample_rate_code_o;
    wire [4:0] limit_status_o;
    wire [1:0] crit_status_o;
    wire [3:0] cfg_bits = {standby_o, extended_range_o, series_resistance_comp_off_o,
        dynamic_averaging_off_o};
    int fail_count = 0;
    int total_checks = 0;
    int i;
    logic [7:0] ra [21] = '{8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0A, 8'h0B,
        8'h0C, 8'h0D, 8'h0E, 8'h0F, 8'h11, 8'h12, 8'h13, 8'h14, 8'h19, 8'h20, 8'h21, 8'h10};
    logic [7:0] rv [21] = '{8'h00, 8'h06, 8'h55, 8'h00, 8'h55, 8'h00, 8'h00, 8'h06, 8'h55,
        8'h00, 8'h55, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h55, 8'h55, 8'h0A, 8'h00};
    logic [10:0] ci [6] = '{11'h181, 11'h180, 11'h080, 11'h100, 11'h100, 11'h100};
    logic [10:0] co [6] = '{11'h100, 11'h180, 11'h081, 11'h080, 11'h181, 11'h100};
    logic [5:0] cs [6] = '{6'h10, 6'h00, 6'h08, 6'h02, 6'h04, 6'h21};
    logic [3:0] rc_code [4] = '{4'h6, 4'h8, 4'hB, 4'hF};
    int rc_gap [4] = '{64, 16, 256, 256};

    always #4 core_clk_i = ~core_clk_i;

    tmc_conv_model #(.DELAY(2)) u_conv (.clk_i(core_clk_i), .reset_n_i(reset_n_i),
        .start_i(conv_start_o), .inner_set_i(t_in), .outer_set_i(t_out),
        .fault_set_i(t_flt), .done_o(conv_done_i), .inner_o(inner_temp_i),
        .outer_o(outer_temp_i), .fault_o(diode_fault_i));

    tmc_core #(.TICK_CYCLES(4)) DUT (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .conv_start_o(conv_start_o),
        .conv_done_i(conv_done_i), .inner_temp_i(inner_temp_i),
        .outer_temp_i(outer_temp_i), .diode_fault_i(diode_fault_i), .standby_o(standby_o),
        .extended_range_o(extended_range_o),
        .series_resistance_comp_off_o(series_resistance_comp_off_o),
        .dynamic_averaging_off_o(dynamic_averaging_off_o),
        .sample_rate_code_o(sample_rate_code_o), .busy_o(busy_o),
        .status_clear_i(status_clear_i), .limit_status_o(limit_status_o),
        .crit_status_o(crit_status_o), .alert_n_o(alert_n_o), .crit_n_o(crit_n_o));

    task wr(input [7:0] a, input [7:0] d);
        @(negedge core_clk_i);
        reg_wr_i = 1'b1;
        reg_addr_i = a;
        reg_wdata_i = d;
        @(negedge core_clk_i);
        reg_wr_i = 1'b0;
    endtask

    task rc(input [7:0] a, input [7:0] e);
        @(negedge core_clk_i);
        reg_rd_i = 1'b1;
        reg_addr_i = a;
        @(negedge core_clk_i);
        reg_rd_i = 1'b0;
        `CHK(reg_rdata_o, e)
    endtask

    task clr();
        @(negedge core_clk_i);
        status_clear_i = 1'b1;
        @(negedge core_clk_i);
        status_clear_i = 1'b0;
    endtask

    // one-shot and wait for busy to drop
    task conv();
        int n;
        wr(8'h0F, 8'hA5);
        n = 0;
        while (busy_o !== 1'b0 && n < 50) begin
            @(negedge core_clk_i);
            n++;
        end
    endtask

    task gap(input int e);
        int n;
        n = 0;
        while (conv_start_o !== 1'b1 && n < 600) begin
            @(negedge core_clk_i);
            n++;
        end
        n = 0;
        do begin
            @(negedge core_clk_i);
            n++;
        end while (conv_start_o !== 1'b1 && n < 600);
        `CHK(n, e)
    endtask

    task summarize();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial begin
        #160000;
        fail_count++;
        summarize();
    end

    initial begin
        repeat (3) @(posedge core_clk_i);
        @(negedge core_clk_i);
        reset_n_i = 1'b1;
        for (i = 0; i < 21; i++) begin
            rc(ra[i], rv[i]);
        end
        wr(8'h03, 8'hFF);
        rc(8'h09, 8'hF6);
        `CHK(cfg_bits, 4'hF)
        wr(8'h09, 8'h40);
        rc(8'h03, 8'h40);
        `CHK(cfg_bits, 4'h8)
        wr(8'h0A, 8'h4F);
        rc(8'h04, 8'h0F);
        `CHK(sample_rate_code_o, 4'hF)
        wr(8'h0B, 8'h30);
        rc(8'h05, 8'h30);
        wr(8'h0C, 8'h10);
        rc(8'h06, 8'h10);
        wr(8'h0D, 8'h30);
        rc(8'h07, 8'h30);
        wr(8'h0E, 8'h10);
        rc(8'h08, 8'h10);
        wr(8'h13, 8'hFF);
        rc(8'h13, 8'hE0);
        wr(8'h13, 8'h00);
        wr(8'h11, 8'hA5);
        wr(8'h12, 8'h5A);
        rc(8'h11, 8'hA5);
        rc(8'h12, 8'h5A);
        for (i = 0; i < 6; i++) begin
            clr();
            t_in = ci[i];
            t_out = co[i];
            t_flt = cs[i][5];
            conv();
            `CHK(limit_status_o, cs[i][4:0])
            `CHK(alert_n_o, (cs[i][4:0] == 5'h00))
        end
        t_flt = 1'b0;
        clr();
        wr(8'h03, 8'hC0);
        t_in = 11'h181;
        t_out = 11'h100;
        conv();
        `CHK(limit_status_o, 5'h10)
        `CHK(alert_n_o, 1'b1)
        wr(8'h03, 8'hE0);
        conv();
        `CHK(alert_n_o, 1'b0)
        t_in = 11'h130;
        conv();
        `CHK(alert_n_o, 1'b0)
        t_in = 11'h12F;
        conv();
        `CHK(alert_n_o, 1'b1)
        t_in = 11'h080;
        conv();
        `CHK(alert_n_o, 1'b1)
        t_in = 11'h2A9;
        conv();
        `CHK({crit_n_o, crit_status_o}, 3'b001)
        t_in = 11'h258;
        conv();
        `CHK(crit_n_o, 1'b0)
        t_in = 11'h257;
        conv();
        `CHK(crit_n_o, 1'b1)
        wr(8'h20, 8'h20);
        repeat (20) @(negedge core_clk_i);
        `CHK(crit_n_o, 1'b1)
        conv();
        `CHK(crit_n_o, 1'b0)
        t_out = 11'h2A9;
        conv();
        `CHK(crit_status_o, 2'b11)
        wr(8'h03, 8'h00);
        repeat (10) @(negedge core_clk_i);
        wr(8'h0F, 8'h00);
        `CHK(busy_o, 1'b0)
        for (i = 0; i < 4; i++) begin
            wr(8'h04, {4'h0, rc_code[i]});
            gap(rc_gap[i]);
        end
        summarize();
    end
endmodule // tb_temp_monitor_control_limits

/* verif/tmc_conv_model.sv */
`timescale 1ns/1ps
module tmc_conv_model #(
    parameter DELAY = 2
) (
    // clock and reset
    input wire clk_i,
    input wire reset_n_i,
    // requested readings
    input wire start_i,
    input wire [10:0] inner_set_i,
    input wire [10:0] outer_set_i,
    input wire fault_set_i,
    // towards the core
    output reg done_o,
    output wire [10:0] inner_o,
    output wire [10:0] outer_o,
    output wire fault_o
);
    reg [3:0] cnt_ff;
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cnt_ff <= 4'h0;
            done_o <= 1'b0;
        end else begin
            done_o <= (cnt_ff == 4'h1);
            if (start_i)
                cnt_ff <= DELAY[3:0];
            else if (cnt_ff != 4'h0)
                cnt_ff <= cnt_ff - 4'h1;
        end
    end
    // readings invalid outside the done cycle
    assign inner_o = done_o ? inner_set_i : ~inner_set_i;
    assign outer_o = done_o ? outer_set_i : ~outer_set_i;
    assign fault_o = done_o ? fault_set_i : ~fault_set_i;
endmodule // tmc_conv_model

/* verif/tmc_core_properties.sv */
`timescale 1ns/1ps
module tmc_core_props #(
    parameter TICK_CYCLES = 4
) (
    // clock and reset
    input wire core_clk_i,
    input wire reset_n_i,
    // register access
    input wire reg_wr_i,
    input wire reg_rd_i,
    input wire [7:0] reg_addr_i,
    input wire [7:0] reg_rdata_o,
    // conversion and outputs
    input wire conv_start_o,
    input wire conv_done_i,
    input wire standby_o,
    input wire extended_range_o,
    input wire series_resistance_comp_off_o,
    input wire dynamic_averaging_off_o,
    input wire [3:0] sample_rate_code_o,
    input wire busy_o,
    input wire status_clear_i,
    input wire [4:0] limit_status_o,
    input wire [1:0] crit_status_o,
    input wire crit_n_o
);
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!reset_n_i);

    AST_START_BUSY: assert property (conv_start_o |-> busy_o)
        else $error("busy low during start");
    AST_DONE_IDLE: assert property (busy_o && conv_done_i |=> !busy_o)
        else $error("busy stuck after done");
    AST_ONESHOT: assert property (reg_wr_i && reg_addr_i == 8'h0F && standby_o && !busy_o
        |=> conv_start_o) else $error("one-shot did not start");
    AST_STBY: assert property (standby_o && !reg_wr_i |=> !conv_start_o)
        else $error("start in standby");
    AST_CRIT_PIN: assert property (crit_n_o != (|crit_status_o))
        else $error("crit pin differs from crit status");
    AST_STICKY: assert property (!conv_done_i && !status_clear_i
        |=> $stable(limit_status_o)) else $error("status moved without cause");
    AST_CRIT_HOLD: assert property (!(busy_o && conv_done_i) |=> $stable(crit_status_o))
        else $error("crit status moved without conversion");
    AST_ONESHOT_RD: assert property (reg_rd_i && reg_addr_i == 8'h0F
        |=> reg_rdata_o == 8'h00) else $error("one-shot read not zero");
    AST_CFG_HOLD: assert property (!reg_wr_i |=> $stable({standby_o, extended_range_o,
        series_resistance_comp_off_o, dynamic_averaging_off_o, sample_rate_code_o}))
        else $error("settings moved without write");
endmodule // tmc_core_props

bind tmc_core tmc_core_props #(.TICK_CYCLES(TICK_CYCLES)) u_props (
    .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_rdata_o(reg_rdata_o),
    .conv_start_o(conv_start_o), .conv_done_i(conv_done_i), .standby_o(standby_o),
    .extended_range_o(extended_range_o),
    .series_resistance_comp_off_o(series_resistance_comp_off_o),
    .dynamic_averaging_off_o(dynamic_averaging_off_o),
    .sample_rate_code_o(sample_rate_code_o), .busy_o(busy_o),
    .status_clear_i(status_clear_i), .limit_status_o(limit_status_o),
    .crit_status_o(crit_status_o), .crit_n_o(crit_n_o));
